// file: rtl/gg_consts.vh
// Constants for the charge monitor register bank.
// Assumes inclusion by bare name from the rtl folder.
`ifndef GG_CONSTS_VH
`define GG_CONSTS_VH

////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define GG_A_STAT    5'h00
`define GG_A_CTRL    5'h01
`define GG_A_CNT_H   5'h02
`define GG_A_CNT_L   5'h03
`define GG_A_CHI_H   5'h04
`define GG_A_CHI_L   5'h05
`define GG_A_CLO_H   5'h06
`define GG_A_CLO_L   5'h07
`define GG_A_VRES_H  5'h08
`define GG_A_VRES_L  5'h09
`define GG_A_VHI_H   5'h0A
`define GG_A_VHI_L   5'h0B
`define GG_A_VLO_H   5'h0C
`define GG_A_VLO_L   5'h0D
`define GG_A_IRES_H  5'h0E
`define GG_A_IRES_L  5'h0F
`define GG_A_IHI_H   5'h10
`define GG_A_IHI_L   5'h11
`define GG_A_ILO_H   5'h12
`define GG_A_ILO_L   5'h13
`define GG_A_TRES_H  5'h14
`define GG_A_TRES_L  5'h15
`define GG_A_THI     5'h16
`define GG_A_TLO     5'h17
`define GG_A_LAST    5'h17

////////////////////////////////////////////////////////////////////////
// Status bit positions
`define GG_ST_UV     0
`define GG_ST_VOLT   1
`define GG_ST_CLO    2
`define GG_ST_CHI    3
`define GG_ST_TEMP   4
`define GG_ST_OVF    5
`define GG_ST_CUR    6

// Control field positions
`define GG_C_SHDN    0
`define GG_C_PIN_LO  1
`define GG_C_PIN_HI  2
`define GG_C_PRE_LO  3
`define GG_C_PRE_HI  5
`define GG_C_MODE_LO 6
`define GG_C_MODE_HI 7

// Pin configuration, converter mode and channel select codes, prescaler shift cap
`define GG_PIN_CC    2'h1
`define GG_PIN_ALERT 2'h2
`define GG_MODE_OFF  2'h0
`define GG_MODE_ONCE 2'h1
`define GG_MODE_SCAN 2'h2
`define GG_SEL_V     2'h0
`define GG_SEL_I     2'h1
`define GG_SEL_T     2'h2
`define GG_PRE_CAP   4'hC

////////////////////////////////////////////////////////////////////////
// Reset values and full-scale count
`define GG_STAT_RST  8'h01
`define GG_CTRL_RST  8'h3C
`define GG_CNTH_RST  8'h7F
`define GG_HI_RST    8'hFF
`define GG_LO_RST    8'h00
`define GG_FULL      16'hFFFF

// Timing
`define GG_SCAN_GAP_S 10
`define GG_CLK_HZ     10000000
// Ten seconds of clk, sized for the 27-bit pause counter
`define GG_SCAN_GAP_CYC 27'h5F5E100

`endif

// file: rtl/gg_regbank.v
// Register bank, charge counter and alert logic of a battery charge monitor.
// Assumes a serial port engine presents byte accesses synchronous to clk,
// and the integrator and converter report events as one-cycle pulses.
`include "gg_consts.vh"
`default_nettype none

module gg_regbank #(
  parameter [26:0] SCAN_GAP_CYCLES = `GG_SCAN_GAP_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [4:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        ara_done,
  input  wire        integ_tick,
  input  wire        integ_up,
  input  wire        supply_low,
  input  wire        conv_done,
  input  wire [15:0] conv_result,
  output reg         conv_req,
  output reg  [1:0]  conv_sel,
  input  wire        alert_or_full_pin_in,
  output reg         alert_or_full_pin_out,
  output reg         alert_or_full_pin_oe,
  output reg         analog_off
);

  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_CONV = 3'h2;
  localparam [2:0] S_GAP  = 3'h4;
  localparam [26:0] GAP_LAST = SCAN_GAP_CYCLES - 27'h1;

  reg [7:0]  regs [0:23];
  reg [11:0] presc_reg;
  reg [11:0] presc_next;
  reg [2:0]  state_reg;
  reg [26:0] gap_reg;
  reg [15:0] chg_next;
  reg        wrap;
  reg        chi_hit;
  reg        clo_hit;
  reg        v_hit;
  reg        i_hit;
  reg        t_hit;
  reg [3:0]  pre_shift;
  integer    k;

  ////////////////////////////////////////////////////////////////////////
  // Reset contents per address
  function [7:0] rst_val;
    input [4:0] a;
    begin
      case (a)
        `GG_A_STAT:  rst_val = `GG_STAT_RST;
        `GG_A_CTRL:  rst_val = `GG_CTRL_RST;
        `GG_A_CNT_H: rst_val = `GG_CNTH_RST;
        `GG_A_CNT_L,
        `GG_A_CHI_H,
        `GG_A_CHI_L,
        `GG_A_VHI_H,
        `GG_A_VHI_L,
        `GG_A_IHI_H,
        `GG_A_IHI_L,
        `GG_A_THI:   rst_val = `GG_HI_RST;
        default:     rst_val = `GG_LO_RST;
      endcase
    end
  endfunction

  // Host-writable addresses only
  function wr_ok;
    input [4:0] a;
    begin
      case (a)
        `GG_A_STAT,
        `GG_A_VRES_H,
        `GG_A_VRES_L,
        `GG_A_IRES_H,
        `GG_A_IRES_L,
        `GG_A_TRES_H,
        `GG_A_TRES_L: wr_ok = 1'b0;
        default:      wr_ok = (a <= `GG_A_LAST);
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Decoded control and packed words
  wire [7:0]  ctrl     = regs[`GG_A_CTRL];
  wire [1:0]  mode     = ctrl[`GG_C_MODE_HI:`GG_C_MODE_LO];
  wire [2:0]  pre_f    = ctrl[`GG_C_PRE_HI:`GG_C_PRE_LO];
  wire [1:0]  pin_cfg  = ctrl[`GG_C_PIN_HI:`GG_C_PIN_LO];
  wire        shdn     = ctrl[`GG_C_SHDN];
  wire [15:0] chg_cnt  = {regs[`GG_A_CNT_H], regs[`GG_A_CNT_L]};
  wire [15:0] chi      = {regs[`GG_A_CHI_H], regs[`GG_A_CHI_L]};
  wire [15:0] clo      = {regs[`GG_A_CLO_H], regs[`GG_A_CLO_L]};
  wire [15:0] vhi      = {regs[`GG_A_VHI_H], regs[`GG_A_VHI_L]};
  wire [15:0] vlo      = {regs[`GG_A_VLO_H], regs[`GG_A_VLO_L]};
  wire [15:0] ihi      = {regs[`GG_A_IHI_H], regs[`GG_A_IHI_L]};
  wire [15:0] ilo      = {regs[`GG_A_ILO_H], regs[`GG_A_ILO_L]};
  wire [7:0]  thi      = regs[`GG_A_THI];
  wire [7:0]  tlo      = regs[`GG_A_TLO];

  // Counting stops in shutdown or sag; count itself is kept
  wire        count_en = !shdn && !supply_low;
  wire        step     = count_en && integ_tick;
  // Code 11 matches neither compare, so both functions stay off
  wire        cc_load  = (pin_cfg == `GG_PIN_CC) && !alert_or_full_pin_in;
  wire        got_conv = conv_done && (state_reg == S_CONV);
  wire        stat_clr = reg_rd && (reg_addr == `GG_A_STAT);
  wire [11:0] presc_top;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler: M = 4^field, capped at 4096
  always @* begin
    if (pre_f >= 3'h6) begin
      pre_shift = `GG_PRE_CAP;
    end else begin
      pre_shift = {pre_f, 1'b0};
    end
  end

  assign presc_top = 12'hFFF >> (4'hC - pre_shift);

  // Integrator steps move the prescaler; its wrap moves the count
  always @* begin
    presc_next = presc_reg;
    chg_next   = chg_cnt;
    wrap       = 1'b0;
    if (step) begin
      if (integ_up) begin
        // >= covers the factor being lowered mid-count
        if (presc_reg >= presc_top) begin
          presc_next = 12'h000;
          chg_next   = chg_cnt + 16'h0001;
          wrap       = (chg_cnt == `GG_FULL);
        end else begin
          presc_next = presc_reg + 12'h001;
        end
      end else begin
        if (presc_reg == 12'h000) begin
          presc_next = presc_top;
          chg_next   = chg_cnt - 16'h0001;
          wrap       = (chg_cnt == 16'h0000);
        end else if (presc_reg > presc_top) begin
          presc_next = presc_top;
        end else begin
          presc_next = presc_reg - 12'h001;
        end
      end
    end
    if (cc_load) begin
      chg_next = `GG_FULL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Threshold compares
  always @* begin
    chi_hit = step && (chg_next > chi);
    clo_hit = step && (chg_next < clo);
    v_hit   = got_conv && (conv_sel == `GG_SEL_V) &&
              ((conv_result > vhi) || (conv_result < vlo));
    i_hit   = got_conv && (conv_sel == `GG_SEL_I) &&
              ((conv_result > ihi) || (conv_result < ilo));
    // Temperature limits are single bytes against the result's top byte
    t_hit   = got_conv && (conv_sel == `GG_SEL_T) &&
              ((conv_result[15:8] > thi) || (conv_result[15:8] < tlo));
  end

  wire [7:0] stat_set = {1'b0, i_hit, wrap, t_hit, chi_hit, clo_hit, v_hit, supply_low};

  ////////////////////////////////////////////////////////////////////////
  // Register file, flags, pin and outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      for (k = 0; k < 24; k = k + 1) begin
        regs[k] <= rst_val(k[4:0]);
      end
      presc_reg             <= 12'h000;
      reg_rdata             <= 8'h00;
      alert_or_full_pin_out <= 1'b0;
      alert_or_full_pin_oe  <= 1'b0;
      analog_off            <= 1'b0;
    end else begin
      presc_reg  <= presc_next;
      analog_off <= !count_en;
      // Open-drain: only ever pulls low
      alert_or_full_pin_out <= 1'b0;

      // Set wins over the read clear, so no event is lost
      if (stat_clr) begin
        regs[`GG_A_STAT] <= stat_set;
      end else begin
        regs[`GG_A_STAT] <= regs[`GG_A_STAT] | stat_set;
      end

      // Pin latch survives config changes until the response arrives
      if ((pin_cfg == `GG_PIN_ALERT) && (|stat_set[6:1])) begin
        alert_or_full_pin_oe <= 1'b1;
      end else if (ara_done) begin
        alert_or_full_pin_oe <= 1'b0;
      end

      regs[`GG_A_CNT_H] <= chg_next[15:8];
      regs[`GG_A_CNT_L] <= chg_next[7:0];

      if (got_conv) begin
        case (conv_sel)
          `GG_SEL_V: begin
            regs[`GG_A_VRES_H] <= conv_result[15:8];
            regs[`GG_A_VRES_L] <= conv_result[7:0];
          end
          `GG_SEL_I: begin
            regs[`GG_A_IRES_H] <= conv_result[15:8];
            regs[`GG_A_IRES_L] <= conv_result[7:0];
          end
          default: begin
            regs[`GG_A_TRES_H] <= conv_result[15:8];
            regs[`GG_A_TRES_L] <= conv_result[7:0];
          end
        endcase
        // Single sequence finished: back to sleep
        if ((conv_sel == `GG_SEL_T) && (mode == `GG_MODE_ONCE)) begin
          regs[`GG_A_CTRL][`GG_C_MODE_HI:`GG_C_MODE_LO] <= `GG_MODE_OFF;
        end
      end

      // Host write comes last and so wins over hardware updates
      if (reg_wr && wr_ok(reg_addr)) begin
        regs[reg_addr] <= reg_wdata;
      end

      if (reg_rd) begin
        if (reg_addr <= `GG_A_LAST) begin
          reg_rdata <= regs[reg_addr];
        end else begin
          reg_rdata <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencer: voltage, current, temperature
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      gap_reg   <= 27'h0000000;
      conv_req  <= 1'b0;
      conv_sel  <= `GG_SEL_V;
    end else begin
      conv_req <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          // Shutdown bit set: no new sequence; a supply sag alone does not stop one
          if ((mode != `GG_MODE_OFF) && !shdn) begin
            conv_req  <= 1'b1;
            conv_sel  <= `GG_SEL_V;
            state_reg <= S_CONV;
          end
        end
        S_CONV: begin
          if (conv_done) begin
            if (conv_sel == `GG_SEL_T) begin
              if (mode == `GG_MODE_SCAN) begin
                gap_reg   <= 27'h0000000;
                state_reg <= S_GAP;
              end else begin
                state_reg <= S_IDLE;
              end
            end else begin
              conv_sel <= conv_sel + 2'h1;
              conv_req <= 1'b1;
            end
          end
        end
        S_GAP: begin
          // Leaving scan mode ends the pause at once
          if ((mode != `GG_MODE_SCAN) || (gap_reg == GAP_LAST)) begin
            state_reg <= S_IDLE;
          end else begin
            gap_reg <= gap_reg + 27'h0000001;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule // gg_regbank

`default_nettype wire

// file: sim/gg_regbank_assertions.sv
// Port assertions for the charge monitor register bank.
// Assumes a bind from the testbench top, one clock domain.
`default_nettype none
module gg_regbank_assertions (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [4:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ara_done,
  input wire logic       integ_tick,
  input wire logic       supply_low,
  input wire logic       conv_done,
  input wire logic       conv_req,
  input wire logic [1:0] conv_sel,
  input wire logic       alert_or_full_pin_out,
  input wire logic       alert_or_full_pin_oe,
  input wire logic       analog_off
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // No new flag source in the same cycle, else a set wins over the clear
  sequence s_ara_quiet; ara_done && !conv_done && !integ_tick; endsequence
  sequence s_pin_free; !alert_or_full_pin_oe; endsequence
  property p_ara; s_ara_quiet |=> s_pin_free; endproperty
  a_ara: assert property (p_ara) else $error("alert not released");
  property p_oe_hold; alert_or_full_pin_oe && !ara_done |=> alert_or_full_pin_oe; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("alert dropped early");
  property p_oe_rise; $rose(alert_or_full_pin_oe) |-> $past(conv_done) || $past(integ_tick); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("alert without event");
  property p_out0; alert_or_full_pin_out == 1'b0; endproperty
  a_out0: assert property (p_out0) else $error("pin driven high");
  property p_off; supply_low |=> analog_off; endproperty
  a_off: assert property (p_off) else $error("analog on in sag");
  property p_req; conv_req |=> !conv_req; endproperty
  a_req: assert property (p_req) else $error("request too long");
  property p_sel; !conv_req |-> $stable(conv_sel); endproperty
  a_sel: assert property (p_sel) else $error("select moved");
  property p_unmap; reg_rd && reg_addr > 5'h17 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
endmodule // gg_regbank_assertions
`default_nettype wire

// file: sim/gg_conv_model.sv
// Converter model answering each request after a chosen latency.
// Assumes one-cycle conv_req pulses; results are junk outside conv_done.
`default_nettype none
module gg_conv_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        conv_req,
  input  wire logic [1:0]  conv_sel,
  input  wire logic [15:0] v_val,
  input  wire logic [15:0] i_val,
  input  wire logic [15:0] t_val,
  input  wire logic [2:0]  lat,
  output logic             conv_done,
  output logic [15:0]      conv_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy_reg;
  logic [2:0] wait_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      wait_reg <= 3'h0;
      conv_done <= 1'b0;
      conv_result <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_req) begin
        busy_reg <= 1'b1;
        wait_reg <= lat;
      end else if (busy_reg && wait_reg == 3'h0) begin
        busy_reg <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= (conv_sel == 2'h0) ? v_val : (conv_sel == 2'h1) ? i_val : t_val;
      end else if (busy_reg) begin
        wait_reg <= wait_reg - 3'h1;
      end
    end
  end
endmodule // gg_conv_model
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the charge monitor register bank.
// Assumes the converter model and the checker are compiled first.
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ara_done = 0, integ_tick = 0, integ_up = 0;
  logic supply_low = 0, pin_in = 1, conv_done, conv_req, pin_out, pin_oe, analog_off;
  logic [4:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, d, acc, th, tl;
  logic [15:0] conv_result, cnt, hi, lo, vv = 0, iv = 0, tv = 0;
  logic [15:0] lim [4];
  logic [2:0] lat = 0;
  logic [1:0] conv_sel;
  int num_errors = 0, compares = 0, seed = 1, nreq = 0, i, k;
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (conv_req === 1'b1) nreq++;
  gg_regbank #(.SCAN_GAP_CYCLES(27'd20)) u_gg_regbank (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ara_done(ara_done),
    .integ_tick(integ_tick), .integ_up(integ_up), .supply_low(supply_low), .conv_done(conv_done),
    .conv_result(conv_result), .conv_req(conv_req), .conv_sel(conv_sel), .alert_or_full_pin_in(pin_in),
    .alert_or_full_pin_out(pin_out), .alert_or_full_pin_oe(pin_oe), .analog_off(analog_off));
  gg_conv_model u_gg_conv_model (.clk(clk), .rst(rst), .conv_req(conv_req), .conv_sel(conv_sel),
    .v_val(vv), .i_val(iv), .t_val(tv), .lat(lat), .conv_done(conv_done), .conv_result(conv_result));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rst_val(input int a);
    if (a == 0) return 8'h01;
    if (a == 1) return 8'h3C;
    if (a == 2) return 8'h7F;
    if (a inside {3, 4, 5, 10, 11, 16, 17, 22}) return 8'hFF;
    return 8'h00;
  endfunction
  function automatic logic [7:0] chg(input logic [15:0] c);
    return {4'h0, c > hi, c < lo, 2'b00};
  endfunction
  function automatic logic [7:0] cexp();
    return {1'b0, iv > lim[2] || iv < lim[3], 1'b0, tv[15:8] > th || tv[15:8] < tl, 2'b00,
            vv > lim[0] || vv < lim[1], 1'b0};
  endfunction
  // Requests in 150 cycles from a sequence start; per = cycles per conversion
  function automatic int exp_reqs(input int per, input int pause);
    int n;
    n = 0;
    for (int t = 0; t < 150; t += 3 * per + pause)
      for (int j = 0; j < 3; j++) if (t + j * per < 150) n++;
    return n;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobes drop a full cycle before the next access, never twice per step
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask
  task automatic rd(input logic [4:0] a);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    d = reg_rdata;
    cyc(1);
  endtask
  task automatic tk(input logic up);
    integ_up = up;
    integ_tick = 1;
    cyc(1);
    integ_tick = 0;
    cyc(1);
  endtask
  task automatic end_sim;
    $display("counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(8);
    rst = 0;
    for (i = 0; i < 25; i++) begin rd(i[4:0]); `CHK(d, rst_val(i)) end
    rd(0); `CHK(d, 8'h00)
    `CHK(nreq, 0)
    $display("test reset done");
    wr(0, 8'hFF); rd(0); `CHK(d, 8'h00)
    for (i = 4; i < 24; i++) begin
      k = $random(seed);
      wr(i[4:0], k[7:0]);
      rd(i[4:0]);
      `CHK(d, (i inside {8, 9, 14, 15, 20, 21}) ? 8'h00 : k[7:0])
    end
    $display("test access done");
    hi = $random(seed); lo = $random(seed); cnt = 16'hFFFF; acc = 8'h00;
    wr(4, hi[15:8]); wr(5, hi[7:0]); wr(6, lo[15:8]); wr(7, lo[7:0]);
    wr(1, 8'h04); wr(2, 8'hFF); wr(3, 8'hFF); rd(0);
    for (k = 0; k < 40; k++) begin
      i = (k == 0) ? 1 : $random(seed);
      tk(i[0]);
      if (i[0] ? cnt == 16'hFFFF : cnt == 16'h0000) acc = acc | 8'h20;
      cnt = i[0] ? cnt + 16'h1 : cnt - 16'h1;
      acc = acc | chg(cnt);
    end
    rd(0); `CHK(d, acc)
    rd(2); `CHK(d, cnt[15:8])
    rd(3); `CHK(d, cnt[7:0])
    `CHK(pin_oe, 1'b1)
    wr(1, 8'h08); `CHK(pin_oe, 1'b1)
    ara_done = 1; cyc(1); ara_done = 0; cyc(1); `CHK(pin_oe, 1'b0)
    repeat (3) tk(1);
    rd(3); `CHK(d, cnt[7:0])
    tk(1); cnt = cnt + 16'h1;
    rd(3); `CHK(d, cnt[7:0])
    $display("test charge done");
    wr(1, 8'h01); `CHK(analog_off, 1'b1)
    tk(1); rd(3); `CHK(d, cnt[7:0])
    wr(1, 8'h00); rd(0); supply_low = 1; cyc(2); `CHK(analog_off, 1'b1)
    tk(1); rd(0); `CHK(d, 8'h01)
    rd(3); `CHK(d, cnt[7:0])
    supply_low = 0; cyc(2); tk(0); cnt = cnt - 16'h1;
    rd(3); `CHK(d, cnt[7:0])
    pin_in = 0; cyc(2); rd(2); `CHK(d, cnt[15:8])
    wr(1, 8'h02); rd(2); `CHK(d, 8'hFF)
    rd(3); `CHK(d, 8'hFF)
    pin_in = 1;
    $display("test power and pin done");
    for (k = 0; k < 4; k++) begin
      lim[k] = $random(seed);
      wr(5'h0A + 5'(k[0] * 2 + k[1] * 6), lim[k][15:8]);
      wr(5'h0B + 5'(k[0] * 2 + k[1] * 6), lim[k][7:0]);
    end
    {th, tl, vv, iv, tv} = {$random(seed), $random(seed)};
    lat = 3'($random(seed));
    wr(5'h16, th); wr(5'h17, tl); wr(1, 8'h00); rd(0);
    k = nreq;
    wr(1, 8'h40);
    d = 8'h40;
    for (i = 0; i < 50 && d[7:6] !== 2'b00; i++) rd(1);
    if (i == 50) begin num_errors++; end_sim(); end
    `CHK(nreq - k, 3)
    rd(0); `CHK(d, cexp())
    rd(8); `CHK(d, vv[15:8])
    rd(5'h0F); `CHK(d, iv[7:0])
    rd(5'h14); `CHK(d, tv[15:8])
    for (i = 2; i < 4; i++) begin
      wr(1, {i[1:0], 6'h00});
      k = nreq;
      cyc(150);
      `CHK(nreq - k, exp_reqs(int'(lat) + 3, (i == 2) ? 21 : 1))
      // Back to sleep so the next mode starts from idle
      wr(1, 8'h00);
      cyc(60);
    end
    $display("test convert done");
    end_sim();
  end
endmodule // testbench
bind gg_regbank gg_regbank_assertions u_gg_regbank_assertions (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ara_done(ara_done), .integ_tick(integ_tick),
  .supply_low(supply_low), .conv_done(conv_done), .conv_req(conv_req), .conv_sel(conv_sel),
  .alert_or_full_pin_out(alert_or_full_pin_out), .alert_or_full_pin_oe(alert_or_full_pin_oe),
  .analog_off(analog_off));
`default_nettype wire
